//--- hdl/evcnt_pkg.sv
// constants and register map of the event counter block
// How it works
// - wrap copies reload value, counting continues
// - wrap period n+1 down, FFFF-n+1 up
// - run bit starts and stops counting
// - wrap sets sticky request flag until cleared
// - stopped write loads both; running, reload only
// - live count readable; wrap reads FFFF/0000
// - mode bit 4 picks direction source
// - direction change applies at next edge
// - register direction bit: 0 down, 1 up
// - secondary pin direction: low down, high up
// - toggle mode drives pin, inverts per wrap
// - toggle mode and stopped: pin low
// - up-down bits 5-7 enable two-phase decoding
// - normal two-phase: primary edges while secondary high
// - quadruple: all edges of both phases count
// - quadruple up/down by phase edge combination
// - each valid edge changes count by one
// - software picks rising or falling count edge
`default_nettype none
package evcnt_pkg;
    localparam int          NUM_CH           = 5;
    localparam int          CNT_W            = 16;
    localparam int          REG_W            = 8;
    // register indices; byte address is four times the index
    localparam logic [7:0]  IDX_RUN          = 8'h40;
    localparam logic [7:0]  IDX_UPDN         = 8'h44;
    localparam logic [7:0]  IDX_MODE0        = 8'h56;
    localparam logic [7:0]  IDX_TIMER0       = 8'h60;
    localparam logic [7:0]  IDX_FLAG         = 8'h68;
    // field positions
    localparam int          MODE_TOGGLE_BIT  = 2;
    localparam int          MODE_EDGE_BIT    = 3;
    localparam int          MODE_DIRSRC_BIT  = 4;
    localparam int          UPDN_QUAD_LSB    = 5;
    localparam int          UPDN_QUAD_MSB    = 7;
    localparam int          QUAD_FIRST_CH    = 2;
    localparam int          QUADRUPLE_CH     = 4;
    // values
    localparam logic [15:0] CNT_MAX          = 16'hffff;
    localparam logic [15:0] CNT_MIN          = 16'h0000;
    localparam logic [15:0] CNT_ONE          = 16'h0001;
    localparam logic [7:0]  REG_RESET        = 8'h00;
    localparam logic [1:0]  HTRANS_NONSEQ    = 2'h2;
    localparam logic [1:0]  HRESP_OKAY       = 2'h0;
    localparam logic [21:0] HADDR_HIGH_ZERO  = 22'h000000;
endpackage
`default_nettype wire

//--- hdl/event_counter_quadrature_timer.sv
// five-channel reloadable event counter with two-phase decoding, AHB-Lite slave
//
// Local design decision: the AHB-Lite slave port.
`default_nettype none
module event_counter_quadrature_timer
    import evcnt_pkg::*;
(
    input  wire logic              I_CLK,
    input  wire logic              I_RESET,
    input  wire logic              HSEL,
    input  wire logic [31:0]       HADDR,
    input  wire logic [1:0]        HTRANS,
    input  wire logic              HWRITE,
    input  wire logic [2:0]        HSIZE,
    input  wire logic [31:0]       HWDATA,
    input  wire logic              HREADY,
    output logic      [31:0]       HRDATA,
    output logic                   HREADYOUT,
    output logic      [1:0]        HRESP,
    input  wire logic [NUM_CH-1:0] I_PRIMARY_IN,
    input  wire logic [NUM_CH-1:0] I_SECONDARY_IN,
    input  wire logic [NUM_CH-1:0] I_IRQ_ACK,
    output logic      [NUM_CH-1:0] O_SECONDARY_OUT,
    output logic      [NUM_CH-1:0] O_SECONDARY_OE,
    output logic      [NUM_CH-1:0] O_IRQ_FLAG
);
    logic [NUM_CH-1:0] p_meta_reg;
    logic [NUM_CH-1:0] p_sync_reg;
    logic [NUM_CH-1:0] p_prev_reg;
    logic [NUM_CH-1:0] s_meta_reg;
    logic [NUM_CH-1:0] s_sync_reg;
    logic [NUM_CH-1:0] s_prev_reg;
    logic [REG_W-1:0]  run_reg;
    logic [REG_W-1:0]  updn_reg;
    logic [REG_W-1:0]  mode_reg     [NUM_CH];
    logic [CNT_W-1:0]  cnt_reg      [NUM_CH];
    logic [CNT_W-1:0]  reload_reg   [NUM_CH];
    logic [NUM_CH-1:0] wrap_up_pend_reg;
    logic [NUM_CH-1:0] wrap_dn_pend_reg;
    logic [7:0]        addr_idx_reg;
    logic              wr_pend_reg;
    logic [NUM_CH-1:0] pr;
    logic [NUM_CH-1:0] pf;
    logic [NUM_CH-1:0] sr;
    logic [NUM_CH-1:0] sf;
    logic [NUM_CH-1:0] quad_en;
    logic [NUM_CH-1:0] ev_up;
    logic [NUM_CH-1:0] ev_dn;
    logic [NUM_CH-1:0] wrap_up;
    logic [NUM_CH-1:0] wrap_dn;
    logic [NUM_CH-1:0] wr_tmr;
    logic              addr_take;
    logic              rd_take;

    // AHB helpers
    function automatic logic [7:0] reg_index(input logic [31:0] a);
        return a[9:2];
    endfunction

    function automatic logic mapped(input logic [31:0] a);
        return a[31:10] == HADDR_HIGH_ZERO;
    endfunction

    assign addr_take = HSEL && HREADY && (HTRANS == HTRANS_NONSEQ);
    assign rd_take   = addr_take && !HWRITE;

    // two-stage synchronisers, then previous-value stage for edges
    always_ff @(posedge I_CLK) begin
        if (I_RESET) begin
            p_meta_reg <= '0;
            p_sync_reg <= '0;
            p_prev_reg <= '0;
            s_meta_reg <= '0;
            s_sync_reg <= '0;
            s_prev_reg <= '0;
        end else begin
            p_meta_reg <= I_PRIMARY_IN;
            p_sync_reg <= p_meta_reg;
            p_prev_reg <= p_sync_reg;
            s_meta_reg <= I_SECONDARY_IN;
            s_sync_reg <= s_meta_reg;
            s_prev_reg <= s_sync_reg;
        end
    end

    assign pr = p_sync_reg & ~p_prev_reg;
    assign pf = ~p_sync_reg & p_prev_reg;
    assign sr = s_sync_reg & ~s_prev_reg;
    assign sf = ~s_sync_reg & s_prev_reg;
    assign quad_en = {updn_reg[UPDN_QUAD_MSB:UPDN_QUAD_LSB], 2'h0};

    // count event decode per channel
    always_comb begin
        ev_up = '0;
        ev_dn = '0;
        for (int i = 0; i < NUM_CH; i++) begin
            if (quad_en[i] && i == QUADRUPLE_CH) begin
                ev_up[i] = (pr[i] & s_sync_reg[i]) | (pf[i] & ~s_sync_reg[i]) |
                           (sr[i] & ~p_sync_reg[i]) | (sf[i] & p_sync_reg[i]);
                ev_dn[i] = (pf[i] & s_sync_reg[i]) | (pr[i] & ~s_sync_reg[i]) |
                           (sr[i] & p_sync_reg[i]) | (sf[i] & ~p_sync_reg[i]);
            end else if (quad_en[i]) begin
                ev_up[i] = pr[i] & s_sync_reg[i];
                ev_dn[i] = pf[i] & s_sync_reg[i];
            end else begin
                if ((mode_reg[i][MODE_EDGE_BIT] ? pr[i] : pf[i])) begin
                    if (mode_reg[i][MODE_DIRSRC_BIT] ? s_sync_reg[i] : updn_reg[i]) begin
                        ev_up[i] = 1'b1;
                    end else begin
                        ev_dn[i] = 1'b1;
                    end
                end
            end
            ev_up[i] = ev_up[i] & run_reg[i];
            ev_dn[i] = ev_dn[i] & run_reg[i];
            wrap_up[i] = ev_up[i] && (cnt_reg[i] == CNT_MAX);
            wrap_dn[i] = ev_dn[i] && (cnt_reg[i] == CNT_MIN);
            wr_tmr[i] = wr_pend_reg && (addr_idx_reg == IDX_TIMER0 + 8'(i));
        end
    end

    // bus address phase capture
    always_ff @(posedge I_CLK) begin
        if (I_RESET) begin
            addr_idx_reg <= 8'h00;
            wr_pend_reg  <= 1'b0;
        end else begin
            wr_pend_reg <= addr_take && HWRITE && mapped(HADDR);
            if (addr_take) begin
                addr_idx_reg <= reg_index(HADDR);
            end
        end
    end

    // control registers
    always_ff @(posedge I_CLK) begin
        if (I_RESET) begin
            run_reg  <= REG_RESET;
            updn_reg <= REG_RESET;
            for (int i = 0; i < NUM_CH; i++) begin
                mode_reg[i] <= REG_RESET;
            end
        end else if (wr_pend_reg) begin
            if (addr_idx_reg == IDX_RUN) begin
                run_reg <= HWDATA[REG_W-1:0];
            end
            if (addr_idx_reg == IDX_UPDN) begin
                updn_reg <= HWDATA[REG_W-1:0];
            end
            for (int i = 0; i < NUM_CH; i++) begin
                if (addr_idx_reg == IDX_MODE0 + 8'(i)) begin
                    mode_reg[i] <= HWDATA[REG_W-1:0];
                end
            end
        end
    end

    // counters and reload registers
    always_ff @(posedge I_CLK) begin
        if (I_RESET) begin
            wrap_up_pend_reg <= '0;
            wrap_dn_pend_reg <= '0;
            for (int i = 0; i < NUM_CH; i++) begin
                cnt_reg[i]    <= CNT_MIN;
                reload_reg[i] <= CNT_MIN;
            end
        end else begin
            wrap_up_pend_reg <= wrap_up;
            wrap_dn_pend_reg <= wrap_dn;
            for (int i = 0; i < NUM_CH; i++) begin
                if (wr_tmr[i]) begin
                    reload_reg[i] <= HWDATA[CNT_W-1:0];
                end
                if (wr_tmr[i] && !run_reg[i]) begin
                    cnt_reg[i] <= HWDATA[CNT_W-1:0];
                end else if (wrap_up[i] || wrap_dn[i]) begin
                    cnt_reg[i] <= reload_reg[i];
                end else if (ev_up[i]) begin
                    cnt_reg[i] <= cnt_reg[i] + CNT_ONE;
                end else if (ev_dn[i]) begin
                    cnt_reg[i] <= cnt_reg[i] - CNT_ONE;
                end
            end
        end
    end

    // sticky request flags; set beats clear
    always_ff @(posedge I_CLK) begin
        if (I_RESET) begin
            O_IRQ_FLAG <= '0;
        end else begin
            O_IRQ_FLAG <= ((wr_pend_reg && addr_idx_reg == IDX_FLAG) ?
                           (O_IRQ_FLAG & HWDATA[NUM_CH-1:0]) : O_IRQ_FLAG) &
                          ~I_IRQ_ACK | wrap_up | wrap_dn;
        end
    end

    // secondary pin toggle output
    always_ff @(posedge I_CLK) begin
        if (I_RESET) begin
            O_SECONDARY_OUT <= '0;
            O_SECONDARY_OE  <= '0;
        end else begin
            for (int i = 0; i < NUM_CH; i++) begin
                O_SECONDARY_OE[i] <= mode_reg[i][MODE_TOGGLE_BIT];
                if (!run_reg[i]) begin
                    O_SECONDARY_OUT[i] <= 1'b0;
                end else if (wrap_up[i] || wrap_dn[i]) begin
                    O_SECONDARY_OUT[i] <= ~O_SECONDARY_OUT[i];
                end
            end
        end
    end

    // read data, prepared in the address phase
    always_ff @(posedge I_CLK) begin
        if (I_RESET) begin
            HRDATA    <= 32'h00000000;
            HREADYOUT <= 1'b0;
            HRESP     <= HRESP_OKAY;
        end else begin
            HREADYOUT <= 1'b1;
            HRESP     <= HRESP_OKAY;
            if (rd_take) begin
                HRDATA <= 32'h00000000;
                if (mapped(HADDR)) begin
                    if (reg_index(HADDR) == IDX_RUN) begin
                        HRDATA <= {24'h000000, run_reg};
                    end
                    if (reg_index(HADDR) == IDX_UPDN) begin
                        HRDATA <= {24'h000000, updn_reg};
                    end
                    if (reg_index(HADDR) == IDX_FLAG) begin
                        HRDATA <= {27'h0000000, O_IRQ_FLAG};
                    end
                    for (int i = 0; i < NUM_CH; i++) begin
                        if (reg_index(HADDR) == IDX_MODE0 + 8'(i)) begin
                            HRDATA <= {24'h000000, mode_reg[i]};
                        end
                        if (reg_index(HADDR) == IDX_TIMER0 + 8'(i)) begin
                            HRDATA <= {16'h0000, wrap_dn_pend_reg[i] ? CNT_MAX :
                                       wrap_up_pend_reg[i] ? CNT_MIN : cnt_reg[i]};
                        end
                    end
                end
            end
        end
    end

    // checks
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (I_RESET);

    AST_RELOAD_ON_UNDERFLOW: assert property (
        wrap_dn[0] && !wr_tmr[0] |=> cnt_reg[0] == $past(reload_reg[0]))
        else $error("underflow did not reload counter");
    AST_FLAG_ON_OVERFLOW: assert property (
        wrap_up[1] |=> O_IRQ_FLAG[1])
        else $error("overflow did not set request flag");
    AST_STOPPED_HOLDS: assert property (
        !run_reg[0] && !wr_tmr[0] |=> $stable(cnt_reg[0]))
        else $error("counter moved while stopped");
    AST_STOPPED_WRITE_LOADS: assert property (
        !run_reg[1] && wr_tmr[1] |=> cnt_reg[1] == $past(HWDATA[CNT_W-1:0]))
        else $error("stopped write did not load counter");
    AST_READ_AT_UNDERFLOW: assert property (
        rd_take && reg_index(HADDR) == IDX_TIMER0 && mapped(HADDR) && wrap_dn_pend_reg[0]
        |=> HRDATA == {16'h0000, CNT_MAX})
        else $error("read at underflow not all ones");
    AST_DIRECTION_SOURCE: assert property (
        ev_up[0] |-> (mode_reg[0][MODE_DIRSRC_BIT] ? s_sync_reg[0] : updn_reg[0]))
        else $error("up count against selected direction");
    AST_TOGGLE_ON_WRAP: assert property (
        run_reg[0] && (wrap_up[0] || wrap_dn[0]) |=> O_SECONDARY_OUT[0] != $past(O_SECONDARY_OUT[0]))
        else $error("pin did not invert on wrap");
    AST_LOW_WHEN_STOPPED: assert property (
        !run_reg[2] ##1 !run_reg[2] |-> !O_SECONDARY_OUT[2])
        else $error("pin not low while stopped");
    AST_NORMAL_TWO_PHASE: assert property (
        quad_en[2] && run_reg[2] && pr[2] && s_sync_reg[2] |-> ev_up[2])
        else $error("normal decode missed up edge");
    AST_QUADRUPLE_UP: assert property (
        quad_en[4] && run_reg[4] && sr[4] && !p_sync_reg[4] |-> ev_up[4] && !ev_dn[4])
        else $error("quadruple decode missed up edge");
    AST_STEP_ONE: assert property (
        ev_up[0] && !wrap_up[0] && !wr_tmr[0] |=> cnt_reg[0] == $past(cnt_reg[0]) + CNT_ONE)
        else $error("count step not one");
    AST_SYNC_DEPTH: assert property (
        p_sync_reg[3] == $past(I_PRIMARY_IN[3], 2))
        else $error("primary pin not two-stage synchronised");
    AST_RELOAD_ON_OVERFLOW: assert property (
        wrap_up[1] && !wr_tmr[1] |=> cnt_reg[1] == $past(reload_reg[1]))
        else $error("overflow did not reload counter");
    AST_FLAG_STICKY: assert property (
        O_IRQ_FLAG[0] && !I_IRQ_ACK[0] && !(wr_pend_reg && addr_idx_reg == IDX_FLAG) |=> O_IRQ_FLAG[0])
        else $error("request flag dropped without clear");
    AST_ACK_CLEARS_FLAG: assert property (
        I_IRQ_ACK[0] && !wrap_up[0] && !wrap_dn[0] |=> !O_IRQ_FLAG[0])
        else $error("accepted request left flag set");
    AST_RUNNING_WRITE_RELOAD_ONLY: assert property (
        run_reg[0] && wr_tmr[0] && !ev_up[0] && !ev_dn[0]
        |=> cnt_reg[0] == $past(cnt_reg[0]) && reload_reg[0] == $past(HWDATA[CNT_W-1:0]))
        else $error("running write touched counter");
    AST_READ_LIVE_COUNT: assert property (
        rd_take && mapped(HADDR) && reg_index(HADDR) == IDX_TIMER0 + 8'h01 &&
        !wrap_up_pend_reg[1] && !wrap_dn_pend_reg[1] |=> HRDATA == {16'h0000, $past(cnt_reg[1])})
        else $error("timer read not live count");
    AST_DIRECTION_AT_EDGE: assert property (
        !pr[0] && !pf[0] |-> !ev_up[0] && !ev_dn[0])
        else $error("count without a valid edge");
    AST_DOWN_BY_REGISTER: assert property (
        ev_dn[0] && !mode_reg[0][MODE_DIRSRC_BIT] |-> !updn_reg[0])
        else $error("down count against direction bit");
    AST_PIN_DIRECTION: assert property (
        run_reg[1] && mode_reg[1][MODE_DIRSRC_BIT] && (mode_reg[1][MODE_EDGE_BIT] ? pr[1] : pf[1])
        |-> (s_sync_reg[1] ? ev_up[1] : ev_dn[1]))
        else $error("pin direction not followed");
    AST_OE_FOLLOWS_MODE: assert property (
        1'b1 |=> O_SECONDARY_OE[0] == $past(mode_reg[0][MODE_TOGGLE_BIT]))
        else $error("pin drive does not follow toggle mode");
    AST_NORMAL_DOWN: assert property (
        quad_en[2] && run_reg[2] && pf[2] && s_sync_reg[2] |-> ev_dn[2] && !ev_up[2])
        else $error("normal decode missed down edge");
    AST_NORMAL_IGNORES_PHASE_B: assert property (
        quad_en[2] && (sr[2] || sf[2]) && !pr[2] && !pf[2] |-> !ev_up[2] && !ev_dn[2])
        else $error("normal decode counted secondary edge");
    AST_QUADRUPLE_ALL_EDGES: assert property (
        quad_en[4] && run_reg[4] && (pr[4] || pf[4]) != (sr[4] || sf[4]) |-> ev_up[4] != ev_dn[4])
        else $error("quadruple decode missed an edge");
    AST_QUADRUPLE_DOWN: assert property (
        quad_en[4] && run_reg[4] && pr[4] && !s_sync_reg[4] |-> ev_dn[4] && !ev_up[4])
        else $error("quadruple decode missed down edge");
    AST_STEP_DOWN_ONE: assert property (
        ev_dn[0] && !wrap_dn[0] && !wr_tmr[0] |=> cnt_reg[0] == $past(cnt_reg[0]) - CNT_ONE)
        else $error("down step not one");
    AST_EDGE_SELECT: assert property (
        run_reg[0] && !mode_reg[0][MODE_EDGE_BIT] && pr[0] |-> !ev_up[0] && !ev_dn[0])
        else $error("rising edge counted in falling mode");
    AST_SECONDARY_SYNC_DEPTH: assert property (
        s_sync_reg[1] == $past(I_SECONDARY_IN[1], 2))
        else $error("secondary pin not two-stage synchronised");

    COV_OVERFLOW:  cover property (wrap_up[0]);
    COV_UNDERFLOW: cover property (wrap_dn[1]);
    COV_QUADRUPLE: cover property (quad_en[4] && ev_dn[4]);
    COV_TOGGLE:    cover property (O_SECONDARY_OE[0] && $rose(O_SECONDARY_OUT[0]));
    COV_WRAP_READ: cover property (rd_take && wrap_dn_pend_reg[0]);

endmodule
`default_nettype wire

//--- tb/evt_source.sv
// event source and two-phase encoder model driving the count pins
`default_nettype none
module evt_source
    import evcnt_pkg::*;
(
    input  wire logic              clk,
    output logic      [NUM_CH-1:0] prim,
    output logic      [NUM_CH-1:0] sec
);
    timeunit 1ns;
    timeprecision 1ps;
    int hold = 3;
    initial begin
        prim = '0;
        sec  = '0;
    end
    // each level held hold cycles, 2 to 5 except 0 before the underflow read; pin left to the design in toggle mode
    task automatic set_pins(input int ch, input logic a, input logic b);
        @(posedge clk);
        prim[ch] <= a;
        sec[ch]  <= b;
        repeat (hold) @(posedge clk);
    endtask
endmodule
`default_nettype wire

//--- tb/tb.sv
// self-checking bench for the event counter block
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import evcnt_pkg::*;
    logic              I_CLK, I_RESET, HSEL, HWRITE, HREADYOUT;
    logic [31:0]       HADDR, HWDATA, HRDATA, rd;
    logic [1:0]        HTRANS, HRESP;
    logic [2:0]        HSIZE;
    logic [NUM_CH-1:0] prim, src_sec, sec_in, ack, sec_out, sec_oe, irq, flg, last_out;
    logic [15:0]       cnt [NUM_CH];
    logic [15:0]       rld [NUM_CH];
    logic [7:0]        mode_r [NUM_CH];
    logic [7:0]        run_r, updn_r;
    logic [1:0]        gray [4] = '{2'b00, 2'b01, 2'b11, 2'b10};
    logic [7:0]        ridx [6] = '{IDX_RUN, IDX_UPDN, IDX_MODE0, IDX_TIMER0, IDX_FLAG, 8'hf0};
    int                failures, cmp_count, ph;
    logic              dir_b;

    // resolved secondary pin level
    assign sec_in = (sec_oe & sec_out) | (~sec_oe & src_sec);

    initial begin
        I_CLK = 1'b0;
        forever #2.5 I_CLK = ~I_CLK;
    end

    event_counter_quadrature_timer i_dut (.I_CLK(I_CLK), .I_RESET(I_RESET), .HSEL(HSEL), .HADDR(HADDR),
        .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADYOUT),
        .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP), .I_PRIMARY_IN(prim),
        .I_SECONDARY_IN(sec_in), .I_IRQ_ACK(ack), .O_SECONDARY_OUT(sec_out),
        .O_SECONDARY_OE(sec_oe), .O_IRQ_FLAG(irq));

    evt_source i_src (.clk(I_CLK), .prim(prim), .sec(src_sec));

    task automatic stop_test;
        if (failures == 0 && cmp_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wait_ready;
        do begin
            @(posedge I_CLK);
        end while (HREADYOUT !== 1'b1);
    endtask

    task automatic bus(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
        @(posedge I_CLK);
        HSEL   <= 1'b1;
        HADDR  <= {HADDR_HIGH_ZERO, idx, 2'h0};
        HWRITE <= wr;
        HTRANS <= HTRANS_NONSEQ;
        wait_ready();
        HSEL   <= 1'b0;
        HTRANS <= 2'h0;
        HWDATA <= wd;
        wait_ready();
        rd = HRDATA;
        chk({30'h0, HRESP}, {30'h0, HRESP_OKAY});
    endtask

    task automatic wreg(input logic [7:0] idx, input logic [15:0] d);
        bus(1'b1, idx, {16'h0, d});
        if (idx == IDX_RUN) run_r = d[7:0];
        if (idx == IDX_UPDN) updn_r = d[7:0];
        if (idx == IDX_FLAG) flg &= d[4:0];
        for (int c = 0; c < NUM_CH; c++) begin
            if (idx == IDX_MODE0 + 8'(c)) mode_r[c] = d[7:0];
            if (idx == IDX_TIMER0 + 8'(c)) begin
                rld[c] = d;
                if (!run_r[c]) cnt[c] = d;
            end
        end
    endtask

    task automatic check(input int ch, input logic wrap);
        logic e;
        bus(1'b0, IDX_TIMER0 + 8'(ch), 32'h0);
        chk(rd, {16'h0, cnt[ch]});
        bus(1'b0, IDX_FLAG, 32'h0);
        chk(rd, {27'h0, flg});
        chk({27'h0, irq}, {27'h0, flg});
        chk({31'h0, sec_oe[ch]}, {31'h0, mode_r[ch][MODE_TOGGLE_BIT]});
        e = run_r[ch] & (last_out[ch] ^ wrap);
        if (mode_r[ch][MODE_TOGGLE_BIT]) chk({31'h0, sec_out[ch]}, {31'h0, e});
        last_out[ch] = e;
    endtask

    task automatic step(input int ch, input logic a, input logic b);
        logic pa, pb, w;
        int d;
        pa = prim[ch];
        pb = src_sec[ch];
        i_src.set_pins(ch, a, b);
        repeat (4) @(posedge I_CLK);
        d = 0;
        w = 1'b0;
        if (ch >= QUAD_FIRST_CH && updn_r[UPDN_QUAD_LSB + ch - QUAD_FIRST_CH]) begin
            if (ch == QUADRUPLE_CH) begin
                if (a != pa) d = (a == b) ? 1 : -1;
                if (b != pb) d = (a != b) ? 1 : -1;
            end else if (a != pa && b) d = a ? 1 : -1;
        end else if (a != pa && a == mode_r[ch][MODE_EDGE_BIT])
            d = (mode_r[ch][MODE_DIRSRC_BIT] ? b : updn_r[ch]) ? 1 : -1;
        if (!run_r[ch]) d = 0;
        if ((d == 1 && cnt[ch] == CNT_MAX) || (d == -1 && cnt[ch] == CNT_MIN)) begin
            cnt[ch] = rld[ch];
            w = 1'b1;
            flg[ch] = 1'b1;
        end else cnt[ch] = cnt[ch] + 16'(d);
        check(ch, w);
    endtask

    initial begin
        I_RESET = 1'b1;
        {HSEL, HWRITE, HTRANS, HADDR, HWDATA, ack} = '0;
        HSIZE = 3'h2;
        {failures, cmp_count, ph} = '0;
        {run_r, updn_r, flg, last_out} = '0;
        for (int c = 0; c < NUM_CH; c++) {cnt[c], rld[c], mode_r[c]} = '0;
        void'($urandom(98600));
        repeat (8) @(posedge I_CLK);
        I_RESET <= 1'b0;
        @(posedge I_CLK);
        foreach (ridx[i]) begin
            bus(1'b0, ridx[i], 32'h0);
            chk(rd, 32'h0);
        end
        // ch0: stopped load, toggle out, falling edge, register direction
        wreg(IDX_TIMER0, 16'h0003);
        wreg(IDX_MODE0, 16'h0004);
        check(0, 1'b0);
        wreg(IDX_RUN, 16'h0001);
        for (int i = 0; i < 10; i++) begin
            step(0, 1'b1, 1'b0);
            step(0, 1'b0, 1'b0);
        end
        wreg(IDX_FLAG, 16'h001e);
        wreg(IDX_TIMER0, 16'h0001);
        check(0, 1'b0);
        for (int i = 0; i < 6; i++) begin
            step(0, 1'b1, 1'b0);
            step(0, 1'b0, 1'b0);
        end
        @(posedge I_CLK);
        ack <= 5'h01;
        @(posedge I_CLK);
        ack <= 5'h00;
        flg[0] = 1'b0;
        check(0, 1'b0);
        wreg(IDX_UPDN, 16'h0003);
        for (int i = 0; i < 3; i++) begin
            step(0, 1'b1, 1'b0);
            step(0, 1'b0, 1'b0);
        end
        // ch1: rising edge up-count near the top, then pin direction
        wreg(IDX_MODE0 + 8'h01, 16'h0008);
        wreg(IDX_TIMER0 + 8'h01, 16'hfffd);
        wreg(IDX_RUN, 16'h0003);
        for (int i = 0; i < 8; i++) begin
            i_src.hold = 2 + int'($urandom % 4);
            step(1, 1'b1, 1'b0);
            step(1, 1'b0, 1'b0);
        end
        wreg(IDX_MODE0 + 8'h01, 16'h0018);
        for (int i = 0; i < 12; i++) begin
            dir_b = 1'($urandom % 2);
            step(1, 1'b0, dir_b);
            step(1, 1'b1, dir_b);
            step(1, 1'b0, dir_b);
        end
        // two-phase: ch2 normal, ch4 quadruple, random direction walk
        wreg(IDX_TIMER0 + 8'h02, 16'h0002);
        wreg(IDX_TIMER0 + 8'h04, 16'h0002);
        wreg(IDX_UPDN, 16'h00a3);
        wreg(IDX_RUN, 16'h0017);
        for (int c = 2; c <= 4; c += 2) begin
            ph = 0;
            for (int i = 0; i < 40; i++) begin
                ph = (ph + (($urandom % 2) ? 1 : 3)) % 4;
                step(c, gray[ph][1], gray[ph][0]);
            end
        end
        // stopped: events ignored, toggle pin low
        wreg(IDX_RUN, 16'h0000);
        step(0, 1'b1, 1'b0);
        step(0, 1'b0, 1'b0);
        // read in the cycle right after an underflow reload
        wreg(IDX_UPDN, 16'h00a2);
        wreg(IDX_TIMER0, 16'h0000);
        wreg(IDX_RUN, 16'h0001);
        i_src.hold = 0;
        i_src.set_pins(0, 1'b1, 1'b0);
        repeat (4) @(posedge I_CLK);
        i_src.set_pins(0, 1'b0, 1'b0);
        repeat (2) @(posedge I_CLK);
        bus(1'b0, IDX_TIMER0, 32'h0);
        chk(rd, {16'h0, CNT_MAX});
        cnt[0] = rld[0];
        flg[0] = 1'b1;
        check(0, 1'b1);
        stop_test();
    end

    initial begin
        #200000;
        failures++;
        stop_test();
    end
endmodule
`default_nettype wire
